/* File: bench/epcas_prom_model.sv */
`timescale 1ns/10ps
module epcas_prom_model
    import epcas_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [LARGE_AW-1:0] addr_i,
    input  wire logic [DATA_W-1:0]   pins_oe_n_i,
    input  wire logic                cs_program_pulse_i,
    input  wire logic                pulse_n_i,
    input  wire logic                out_en_i,
    output logic      [DATA_W-1:0]   data_o
);
    logic [DATA_W-1:0] mem_q [0:LARGE_WORDS-1];
    initial begin
        for (int i = 0; i < LARGE_WORDS; i++) begin
            mem_q[i] = 8'hFF;
        end
    end
    // Pulse with select low clears only pulled-low bits
    always @(posedge clk_i) begin
        if (!pulse_n_i && !cs_program_pulse_i) begin
            mem_q[addr_i] <= mem_q[addr_i] & pins_oe_n_i;
        end
    end
    // Released lines float up through the pull-up
    assign data_o = (out_en_i && cs_program_pulse_i) ? mem_q[addr_i] : 8'hFF;
endmodule : epcas_prom_model

/* File: bench/test_eprom_card_access_sequencer.sv */
`timescale 1ns/10ps
module test_eprom_card_access_sequencer
    import epcas_pkg::*;
;
    localparam int unsigned PC = 10;
    logic clk = 1'b0, rst = 1'b1, rd_req = 1'b0, pgm_req = 1'b0;
    logic sw = 1'b0, hv = 1'b1, cs, pulse_n, prom_oe, busy, done, ok, fail;
    logic oor_n;
    logic [ADDR_W-1:0]   addr = 12'h000;
    logic [DATA_W-1:0]   wr_data = 8'h00, oe_n, prom_q, rd_data, d_unused;
    logic [LARGE_AW-1:0] prom_addr;
    int err_count = 0, n_compared = 0, cyc = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    epcas_card #(.PULSE_CYCLES(PC)) epcas_card_inst (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wr_data),
        .RD_REQ_I(rd_req), .PGM_REQ_I(pgm_req), .PART_SIZE_SWITCH_I(sw),
        .HIGH_VOLTAGE_PRESENT_I(hv), .PROM_DATA_I(prom_q & oe_n),
        .PROM_DATA_O(d_unused), .PROM_DATA_OE_N_O(oe_n),
        .PROM_ADDR_O(prom_addr), .CHIP_SELECT_PROGRAM_CTL_O(cs),
        .PROGRAM_PULSE_ENABLE_N_O(pulse_n), .PROM_OE_O(prom_oe),
        .RD_DATA_O(rd_data), .BUSY_O(busy), .DONE_O(done), .OK_O(ok),
        .FAIL_O(fail), .ADDR_OUT_OF_RANGE_N_O(oor_n));

    epcas_prom_model epcas_prom_model_inst (
        .clk_i(clk), .addr_i(prom_addr), .pins_oe_n_i(oe_n),
        .cs_program_pulse_i(cs), .pulse_n_i(pulse_n), .out_en_i(prom_oe),
        .data_o(prom_q));

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // One request at a falling edge, then watch until done
    task automatic op(input logic rd, input logic pg,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      input logic in_rng, input logic exp_ok,
                      input logic [DATA_W-1:0] exp_rd);
        int n_pulse, n_cs, w;
        logic [DATA_W-1:0] oe_seen;
        logic [LARGE_AW-1:0] exp_a;
        logic prg;
        n_pulse = 0;
        n_cs = 0;
        w = 0;
        prg = !rd && exp_ok;
        oe_seen = 8'hFF;
        exp_a = sw ? {1'b0, a[8:0]} : a[9:0];
        addr = a;
        wr_data = wd;
        rd_req = rd;
        pgm_req = pg;
        @(negedge clk);
        rd_req = 1'b0;
        pgm_req = 1'b0;
        chk("oor_n", 16'(oor_n), 16'(in_rng));
        chk("prom_addr", 16'(prom_addr), 16'(exp_a));
        chk("busy", 16'(busy), 16'(exp_ok));
        while (done !== 1'b1 && w < 100) begin
            if (pulse_n === 1'b0) begin
                n_pulse++;
                oe_seen = oe_n;
                chk("sel_in_pulse", 16'({cs, prom_oe}), 16'h0);
            end
            if (cs === 1'b0) n_cs++;
            @(negedge clk);
            w++;
        end
        chk("done", 16'(done), 16'h1);
        chk("ok", 16'(ok), 16'(exp_ok));
        chk("fail", 16'(fail), 16'(!exp_ok));
        chk("busy_end", 16'(busy), 16'h0);
        chk("prom_d_o", 16'(d_unused), 16'h0);
        chk("pulse_len", 16'(n_pulse), prg ? 16'(PC) : 16'h0);
        chk("cs_len", 16'(n_cs), prg ? 16'(PC + 4) : 16'h0);
        if (prg) chk("oe_n", 16'(oe_seen), 16'(wd));
        if (rd && exp_ok) begin
            chk("rd_data", 16'(rd_data), 16'(exp_rd));
        end
    endtask : op

    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk("rst_cs", 16'(cs), 16'h1);
        chk("rst_pulse", 16'(pulse_n), 16'h1);
        chk("rst_oe_n", 16'(oe_n), 16'hFF);
        chk("rst_flags", 16'({busy, done, ok, fail}), 16'h0);
        op(1'b1, 1'b0, 12'h000, 8'h00, 1'b1, 1'b1, 8'h00);
        op(1'b0, 1'b1, 12'h3FF, 8'hA5, 1'b1, 1'b1, 8'h00);
        op(1'b1, 1'b0, 12'h3FF, 8'h00, 1'b1, 1'b1, 8'h5A);
        op(1'b0, 1'b1, 12'h3FF, 8'h0F, 1'b1, 1'b1, 8'h00);
        op(1'b1, 1'b1, 12'h3FF, 8'h00, 1'b1, 1'b1, 8'hFA);
        op(1'b0, 1'b1, 12'h400, 8'h00, 1'b0, 1'b0, 8'h00);
        op(1'b1, 1'b0, 12'h800, 8'h00, 1'b0, 1'b0, 8'h00);
        hv = 1'b0;
        op(1'b0, 1'b1, 12'h001, 8'h00, 1'b1, 1'b0, 8'h00);
        op(1'b1, 1'b0, 12'h001, 8'h00, 1'b1, 1'b1, 8'h00);
        hv = 1'b1;
        sw = 1'b1;
        op(1'b0, 1'b1, 12'h1FF, 8'h3C, 1'b1, 1'b1, 8'h00);
        op(1'b0, 1'b1, 12'h200, 8'h00, 1'b0, 1'b0, 8'h00);
        op(1'b1, 1'b0, 12'hE00, 8'h00, 1'b0, 1'b0, 8'h00);
        sw = 1'b0;
        op(1'b1, 1'b0, 12'h1FF, 8'h00, 1'b1, 1'b1, 8'hC3);
        tally_and_finish();
    end
endmodule : test_eprom_card_access_sequencer

/* File: rtl/epcas_card.sv */
`timescale 1ns/10ps
module epcas_card
    import epcas_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC
)
(
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WR_DATA_I,
    input  wire logic              RD_REQ_I,
    input  wire logic              PGM_REQ_I,
    input  wire logic              PART_SIZE_SWITCH_I,
    input  wire logic              HIGH_VOLTAGE_PRESENT_I,
    input  wire logic [DATA_W-1:0] PROM_DATA_I,
    output logic [DATA_W-1:0]      PROM_DATA_O,
    output logic [DATA_W-1:0]      PROM_DATA_OE_N_O,
    output logic [LARGE_AW-1:0]    PROM_ADDR_O,
    output logic                   CHIP_SELECT_PROGRAM_CTL_O,
    output logic                   PROGRAM_PULSE_ENABLE_N_O,
    output logic                   PROM_OE_O,
    output logic [DATA_W-1:0]      RD_DATA_O,
    output logic                   BUSY_O,
    output logic                   DONE_O,
    output logic                   OK_O,
    output logic                   FAIL_O,
    output logic                   ADDR_OUT_OF_RANGE_N_O
);

    // ---------------------------------------------
    // Address check and PROM address
    // ---------------------------------------------
    logic addr_out_of_range_n;

    epcas_range u_range (
        .addr_i  (ADDR_I),
        .small_i (PART_SIZE_SWITCH_I),
        .oor_n_o (addr_out_of_range_n)
    );

    always_comb begin
        PROM_ADDR_O = ADDR_I[LARGE_AW-1:0];
        if (PART_SIZE_SWITCH_I) begin
            PROM_ADDR_O[LARGE_AW-1] = 1'b0;
        end
    end

    // ---------------------------------------------
    // Sequencer
    // ---------------------------------------------
    epcas_seq_t s_q;
    epcas_seq_t s_d;
    logic [CNT_W-1:0] pulse_last;

    assign pulse_last = CNT_W'(PULSE_CYCLES - 1);

    always_comb begin
        s_d = s_q;
        s_d.res.done = 1'b0;
        unique case (s_q.state)
            EPCAS_IDLE: begin
                if (RD_REQ_I || PGM_REQ_I) begin
                    s_d.res.ok   = 1'b0;
                    s_d.res.fail = 1'b0;
                    s_d.is_read  = RD_REQ_I;
                    if (!addr_out_of_range_n) begin
                        s_d.res.done = 1'b1;
                        s_d.res.fail = 1'b1;
                    end else if (RD_REQ_I) begin
                        s_d.state = EPCAS_READ;
                    end else if (!HIGH_VOLTAGE_PRESENT_I) begin
                        s_d.res.done = 1'b1;
                        s_d.res.fail = 1'b1;
                    end else begin
                        s_d.state = EPCAS_CS_LOW;
                    end
                end
            end
            EPCAS_READ: begin
                // PROM drives ones when erased; byte returned inverted
                s_d.res.rd_data = ~PROM_DATA_I;
                s_d.res.ok      = 1'b1;
                s_d.res.done    = 1'b1;
                s_d.state       = EPCAS_IDLE;
            end
            EPCAS_CS_LOW: begin
                s_d.cs_program_pulse = 1'b1;
                s_d.state   = EPCAS_DATA_ON;
            end
            EPCAS_DATA_ON: begin
                s_d.wr_en = 1'b1;
                s_d.state = EPCAS_PULSE;
            end
            EPCAS_PULSE: begin
                s_d.pulse_n = 1'b0;
                s_d.cnt     = '0;
                s_d.state   = EPCAS_PULSE_OFF;
            end
            EPCAS_PULSE_OFF: begin
                if (s_q.cnt == pulse_last) begin
                    s_d.pulse_n = 1'b1;
                    s_d.state   = EPCAS_DATA_OFF;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            EPCAS_DATA_OFF: begin
                s_d.wr_en = 1'b0;
                s_d.state = EPCAS_CS_HIGH;
            end
            EPCAS_CS_HIGH: begin
                s_d.cs_program_pulse  = 1'b0;
                s_d.res.ok   = 1'b1;
                s_d.res.done = 1'b1;
                s_d.state    = EPCAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_q.state   <= EPCAS_IDLE;
            s_q.cnt     <= '0;
            s_q.cs_program_pulse <= 1'b0;
            s_q.wr_en   <= 1'b0;
            s_q.pulse_n <= 1'b1;
            s_q.is_read <= 1'b0;
            s_q.res     <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    // Select control high means read level
    assign CHIP_SELECT_PROGRAM_CTL_O = ~s_q.cs_program_pulse;
    assign PROGRAM_PULSE_ENABLE_N_O  = s_q.pulse_n;
    // Open drain: only zeros pulled, ones left to cells
    assign PROM_DATA_O      = '0;
    assign PROM_DATA_OE_N_O = s_q.wr_en ? WR_DATA_I
                                        : {DATA_W{1'b1}};
    assign PROM_OE_O        = ~s_q.cs_program_pulse;
    assign RD_DATA_O        = s_q.res.rd_data;
    assign BUSY_O           = (s_q.state != EPCAS_IDLE);
    assign DONE_O           = s_q.res.done;
    assign OK_O             = s_q.res.ok;
    assign FAIL_O           = s_q.res.fail;
    assign ADDR_OUT_OF_RANGE_N_O = addr_out_of_range_n;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    property p_range_large;
        @(posedge CLK_I) disable iff (RST_I)
        !PART_SIZE_SWITCH_I |-> (ADDR_OUT_OF_RANGE_N_O == (ADDR_I < 12'h400));
    endproperty
    a_range_large: assert property (p_range_large)
        else $error("large range flag wrong");

    property p_range_small;
        @(posedge CLK_I) disable iff (RST_I)
        PART_SIZE_SWITCH_I |-> (ADDR_OUT_OF_RANGE_N_O == (ADDR_I < 12'h200))
            && !PROM_ADDR_O[9];
    endproperty
    a_range_small: assert property (p_range_small)
        else $error("small range flag wrong");

    property p_abort_range;
        @(posedge CLK_I) disable iff (RST_I)
        (s_q.state == EPCAS_IDLE && (RD_REQ_I || PGM_REQ_I)
            && !ADDR_OUT_OF_RANGE_N_O) |=> DONE_O && FAIL_O && !BUSY_O;
    endproperty
    a_abort_range: assert property (p_abort_range)
        else $error("range abort missing");

    property p_abort_hv;
        @(posedge CLK_I) disable iff (RST_I)
        (s_q.state == EPCAS_IDLE && !RD_REQ_I && PGM_REQ_I
            && !HIGH_VOLTAGE_PRESENT_I) |=> FAIL_O && DONE_O
            && PROGRAM_PULSE_ENABLE_N_O;
    endproperty
    a_abort_hv: assert property (p_abort_hv)
        else $error("voltage abort missing");

    property p_order;
        @(posedge CLK_I) disable iff (RST_I)
        $fell(PROGRAM_PULSE_ENABLE_N_O) |->
            !CHIP_SELECT_PROGRAM_CTL_O && s_q.wr_en && !s_q.is_read;
    endproperty
    a_order: assert property (p_order)
        else $error("pulse before select or data");

    property p_pulse_hold;
        @(posedge CLK_I) disable iff (RST_I)
        $fell(PROGRAM_PULSE_ENABLE_N_O) |->
            !PROGRAM_PULSE_ENABLE_N_O [*8];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold)
        else $error("pulse too short");

    property p_release;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(PROGRAM_PULSE_ENABLE_N_O) |-> s_q.wr_en
            ##1 !s_q.wr_en && !CHIP_SELECT_PROGRAM_CTL_O
            ##1 CHIP_SELECT_PROGRAM_CTL_O && DONE_O && OK_O;
    endproperty
    a_release: assert property (p_release)
        else $error("release order wrong");

    property p_read;
        @(posedge CLK_I) disable iff (RST_I)
        s_q.state == EPCAS_READ |=>
            RD_DATA_O == ~$past(PROM_DATA_I) && DONE_O && OK_O;
    endproperty
    a_read: assert property (p_read)
        else $error("read data not complemented");

    property p_data;
        @(posedge CLK_I) disable iff (RST_I)
        s_q.wr_en |-> PROM_DATA_OE_N_O == WR_DATA_I
            && !CHIP_SELECT_PROGRAM_CTL_O && !PROM_OE_O;
    endproperty
    a_data: assert property (p_data)
        else $error("write byte not driven");

endmodule : epcas_card

/* File: rtl/epcas_pkg.sv */
// Function
// - Flag addresses beyond switch-selected capacity, active low
// - Larger part holds 1024 bytes
// - Smaller part: 512 bytes, nine address lines
// - Erased reads ones; programming only clears bits
// - All eight write bits driven together
// - Program with pulses on program and select
// - Board requests; card attempts and reports outcome
// - Read returns selected byte on read bus
// - Check range first; abort when out
// - Check high voltage before programming; abort if absent
// - Select low, data on, pulse, 1 ms, reverse
// - Read enables output; byte returned complemented
package epcas_pkg;

    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned LARGE_WORDS  = 1024;
    localparam int unsigned SMALL_WORDS  = 512;
    localparam int unsigned LARGE_AW     = 10;
    localparam int unsigned SMALL_AW     = 9;
    localparam int unsigned CLK_HZ       = 20000000;
    localparam int unsigned PULSE_US     = 1000;
    localparam int unsigned PULSE_CYC    = (CLK_HZ / 1000000) * PULSE_US;
    localparam int unsigned CNT_W        = 16;

    typedef enum logic [2:0] {
        EPCAS_IDLE,
        EPCAS_CS_LOW,
        EPCAS_DATA_ON,
        EPCAS_PULSE,
        EPCAS_PULSE_OFF,
        EPCAS_DATA_OFF,
        EPCAS_CS_HIGH,
        EPCAS_READ
    } epcas_state_t;

    typedef struct packed {
        logic              done;
        logic              ok;
        logic              fail;
        logic [DATA_W-1:0] rd_data;
    } epcas_result_t;

    typedef struct packed {
        epcas_state_t      state;
        logic [CNT_W-1:0]  cnt;
        logic              cs_program_pulse;
        logic              wr_en;
        logic              pulse_n;
        logic              is_read;
        epcas_result_t     res;
    } epcas_seq_t;

endpackage : epcas_pkg

/* File: rtl/epcas_range.sv */
`timescale 1ns/10ps
module epcas_range
    import epcas_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              small_i,
    output logic                   oor_n_o
);
    always_comb begin
        if (small_i) begin
            oor_n_o = ~(|addr_i[ADDR_W-1:SMALL_AW]);
        end else begin
            oor_n_o = ~(|addr_i[ADDR_W-1:LARGE_AW]);
        end
    end
endmodule : epcas_range
